/* File: bmc_pkg.sv */
// package for the boot mode controller: boot modes, strap codes, copy sizes
// assumes nothing beyond a SystemVerilog compiler
package bmc_pkg;
    // boot modes held after the reset release
    typedef enum logic [1:0] {
        BMC_NO_BOOT,
        BMC_HOST_BOOT,
        BMC_MEM_BOOT
    } bmc_mode_t;

    // strap codes on the boot mode pins
    localparam logic [1:0] STRAP_NO_BOOT = 2'h0;
    localparam logic [1:0] STRAP_HOST_BOOT = 2'h1;
    localparam logic [1:0] STRAP_MEM_BOOT = 2'h2;

    // memory boot copy: bytes moved, source base and destination address
    localparam int unsigned COPY_BYTES = 1024;
    localparam logic [31:0] ROM_BASE = 32'h0000_0000;
    localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;

    // reset values of the held straps
    localparam logic RST_PCI_SEL = 1'h0;
    localparam logic RST_BIG_ENDIAN = 1'h0;
endpackage

/* File: bmc_copy_if.sv */
// start and done handshake between the boot controller and the rom copier
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface bmc_copy_if;
    logic start;
    logic big_endian;
    logic done;

    modport ctrl (output start, output big_endian, input done);
    modport copier (input start, input big_endian, output done);
endinterface

/* File: bmc_rom_copier.sv */
// block copy of the boot rom into memory at address zero
// assumes the rom answers each read with one i_rom_valid pulse
`timescale 1ns/100ps
module bmc_rom_copier #(
    parameter int unsigned BYTES = bmc_pkg::COPY_BYTES
) (
    input wire logic i_core_clk,
    input wire logic i_clear,
    bmc_copy_if.copier cp,
    output logic o_rom_rd,
    output logic [31:0] o_rom_addr,
    input wire logic [7:0] i_rom_data,
    input wire logic i_rom_valid,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata
);
    typedef enum logic [1:0] {CP_IDLE, CP_READ, CP_WRITE} bmc_cp_state_t;

    typedef struct packed {
        bmc_cp_state_t state;
        logic [31:0] byte_cnt;
        logic [31:0] acc;
        logic rom_rd;
        logic mem_we;
        logic [31:0] mem_addr;
        logic done;
    } bmc_cp_t;

    bmc_cp_t cur;
    bmc_cp_t next_cur;
    logic [31:0] packed_word;

    // byte packing into words in the selected byte order
    always_comb begin
        if (cp.big_endian) begin
            packed_word = {cur.acc[23:0], i_rom_data};
        end else begin
            packed_word = {i_rom_data, cur.acc[31:8]};
        end
    end

    // single-frame block transfer sequencer
    always_comb begin
        next_cur = cur;
        next_cur.mem_we = 1'b0;
        next_cur.done = 1'b0;
        case (cur.state)
            CP_IDLE: begin
                if (cp.start) begin
                    next_cur.state = CP_READ;
                    next_cur.byte_cnt = 32'h0;
                    next_cur.rom_rd = 1'b1;
                end
            end
            CP_READ: begin
                if (i_rom_valid) begin
                    next_cur.acc = packed_word;
                    next_cur.byte_cnt = cur.byte_cnt + 32'h1;
                    if (cur.byte_cnt[1:0] == 2'h3) begin
                        next_cur.state = CP_WRITE;
                        next_cur.rom_rd = 1'b0;
                        next_cur.mem_we = 1'b1;
                        next_cur.mem_addr = bmc_pkg::BOOT_ADDR
                            + {cur.byte_cnt[31:2], 2'h0};
                    end
                end
            end
            CP_WRITE: begin
                if (cur.byte_cnt == BYTES) begin
                    next_cur.state = CP_IDLE;
                    next_cur.done = 1'b1;
                end else begin
                    next_cur.state = CP_READ;
                    next_cur.rom_rd = 1'b1;
                end
            end
            default: begin
                next_cur.state = CP_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_clear) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign cp.done = cur.done;
    assign o_rom_rd = cur.rom_rd;
    assign o_rom_addr = bmc_pkg::ROM_BASE + cur.byte_cnt;
    assign o_mem_we = cur.mem_we;
    assign o_mem_addr = cur.mem_addr;
    assign o_mem_wdata = cur.acc;
endmodule // bmc_rom_copier

/* File: bmc_boot_ctrl.sv */
// boot mode controller: device reset, strap capture, cpu stall and release
// assumes the pins are asynchronous and host port logic shares i_core_clk
//
// How it works
// - low reset pin holds everything reset
// - reset rising edge starts chosen boot
// - host boot stalls cpu, rest runs
// - host may write memory during stall
// - pci strap picks parallel port or pci
// - interrupt bit releases cpu at zero
// - boot-ending interrupt not pending to cpu
// - bit releases stall only in host boot
// - host may read memory during host boot
// - bit blocks new interrupts until cleared
// - memory boot copies rom to zero
// - bytes packed into words by endianness
// - copy is one automatic block transfer
// - copy completion releases cpu at zero
// - no boot runs from zero at once
`timescale 1ns/100ps
module bmc_boot_ctrl #(
    parameter int unsigned COPY_BYTES = bmc_pkg::COPY_BYTES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_dev_reset_n,
    input wire logic [1:0] i_boot_mode,
    input wire logic i_pci_sel,
    input wire logic i_big_endian,
    input wire logic i_host_irq_set,
    input wire logic i_cpu_irq_clear,
    input wire logic [7:0] i_rom_data,
    input wire logic i_rom_valid,
    output logic o_periph_reset,
    output logic o_cpu_stall,
    output logic o_cpu_start,
    output logic [31:0] o_cpu_boot_addr,
    output logic o_host_access,
    output logic o_host_pci_sel,
    output logic o_host_irq_bit,
    output logic o_cpu_irq,
    output logic o_rom_rd,
    output logic [31:0] o_rom_addr,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata
);
    typedef enum logic [1:0] {
        ST_RESET, ST_HOST_STALL, ST_MEM_STALL, ST_RUN
    } bmc_state_t;

    typedef struct packed {
        logic rst_n_s1;
        logic rst_n_s2;
        logic rst_n_prev;
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
        logic pci_s1;
        logic pci_s2;
        logic be_s1;
        logic be_s2;
        bmc_pkg::bmc_mode_t mode;
        logic pci_sel;
        logic big_endian;
        bmc_state_t state;
        logic periph_reset;
        logic cpu_stall;
        logic cpu_start;
        logic host_access;
        logic irq_bit;
        logic cpu_irq;
        logic copy_start;
    } bmc_top_t;

    bmc_top_t cur;
    bmc_top_t next_cur;
    bmc_copy_if cp ();
    logic dev_in_reset;

    assign dev_in_reset = !cur.rst_n_s2;

    // pin synchronisers, strap capture, boot sequencing and interrupt bit
    always_comb begin
        next_cur = cur;
        next_cur.rst_n_s1 = i_dev_reset_n;
        next_cur.rst_n_s2 = cur.rst_n_s1;
        next_cur.rst_n_prev = cur.rst_n_s2;
        next_cur.mode_s1 = i_boot_mode;
        next_cur.mode_s2 = cur.mode_s1;
        next_cur.pci_s1 = i_pci_sel;
        next_cur.pci_s2 = cur.pci_s1;
        next_cur.be_s1 = i_big_endian;
        next_cur.be_s2 = cur.be_s1;
        next_cur.cpu_start = 1'b0;
        next_cur.cpu_irq = 1'b0;
        next_cur.copy_start = 1'b0;
        if (dev_in_reset) begin
            // hold the device in its reset state
            next_cur.state = ST_RESET;
            next_cur.periph_reset = 1'b1;
            next_cur.cpu_stall = 1'b1;
            next_cur.host_access = 1'b0;
            next_cur.irq_bit = 1'b0;
        end else begin
            case (cur.state)
                ST_RESET: begin
                    if (!cur.rst_n_prev) begin
                        // release edge: capture straps and start boot
                        next_cur.periph_reset = 1'b0;
                        next_cur.pci_sel = cur.pci_s2;
                        next_cur.big_endian = cur.be_s2;
                        case (cur.mode_s2)
                            bmc_pkg::STRAP_HOST_BOOT: begin
                                next_cur.mode = bmc_pkg::BMC_HOST_BOOT;
                                next_cur.state = ST_HOST_STALL;
                                next_cur.host_access = 1'b1;
                            end
                            bmc_pkg::STRAP_MEM_BOOT: begin
                                next_cur.mode = bmc_pkg::BMC_MEM_BOOT;
                                next_cur.state = ST_MEM_STALL;
                                next_cur.copy_start = 1'b1;
                            end
                            default: begin
                                next_cur.mode = bmc_pkg::BMC_NO_BOOT;
                                next_cur.state = ST_RUN;
                                next_cur.cpu_stall = 1'b0;
                                next_cur.cpu_start = 1'b1;
                            end
                        endcase
                    end
                end
                ST_HOST_STALL: begin
                    // only the host interrupt bit ends this stall
                    if (i_host_irq_set
                            && cur.mode == bmc_pkg::BMC_HOST_BOOT) begin
                        next_cur.irq_bit = 1'b1;
                        next_cur.cpu_irq = 1'b0;
                        next_cur.state = ST_RUN;
                        next_cur.cpu_stall = 1'b0;
                        next_cur.cpu_start = 1'b1;
                        next_cur.host_access = 1'b0;
                    end
                end
                ST_MEM_STALL: begin
                    // the host bit is latched but never releases here
                    if (i_host_irq_set && !cur.irq_bit) begin
                        next_cur.irq_bit = 1'b1;
                    end
                    if (cp.done) begin
                        next_cur.state = ST_RUN;
                        next_cur.cpu_stall = 1'b0;
                        next_cur.cpu_start = 1'b1;
                    end
                end
                ST_RUN: begin
                    // a free bit takes a set even beside a clear; a held
                    // bit refuses new interrupts until the cpu clears it
                    if (i_host_irq_set && !cur.irq_bit) begin
                        next_cur.irq_bit = 1'b1;
                        next_cur.cpu_irq = 1'b1;
                    end else if (i_cpu_irq_clear) begin
                        next_cur.irq_bit = 1'b0;
                    end
                end
                default: begin
                    next_cur.state = ST_RESET;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cur <= '0;
            cur.state <= ST_RESET;
            cur.mode <= bmc_pkg::BMC_NO_BOOT;
            cur.pci_sel <= bmc_pkg::RST_PCI_SEL;
            cur.big_endian <= bmc_pkg::RST_BIG_ENDIAN;
            cur.periph_reset <= 1'b1;
            cur.cpu_stall <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign cp.start = cur.copy_start;
    assign cp.big_endian = cur.big_endian;

    // rom to memory block copier
    bmc_rom_copier #(
        .BYTES(COPY_BYTES)
    ) u_copier (
        .i_core_clk(i_core_clk),
        .i_clear(i_rst | dev_in_reset),
        .cp(cp),
        .o_rom_rd(o_rom_rd),
        .o_rom_addr(o_rom_addr),
        .i_rom_data(i_rom_data),
        .i_rom_valid(i_rom_valid),
        .o_mem_we(o_mem_we),
        .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata)
    );

    assign o_periph_reset = cur.periph_reset;
    assign o_cpu_stall = cur.cpu_stall;
    assign o_cpu_start = cur.cpu_start;
    assign o_cpu_boot_addr = bmc_pkg::BOOT_ADDR;
    assign o_host_access = cur.host_access;
    assign o_host_pci_sel = cur.pci_sel;
    assign o_host_irq_bit = cur.irq_bit;
    assign o_cpu_irq = cur.cpu_irq;
endmodule // bmc_boot_ctrl

/* File: bmc_checker.sv */
// port checker for the boot mode controller
// assumes it is bound to bmc_boot_ctrl and sees one clock domain
`timescale 1ns/100ps
module bmc_checker (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_dev_reset_n,
    input wire logic i_host_irq_set,
    input wire logic i_cpu_irq_clear,
    input wire logic o_periph_reset,
    input wire logic o_cpu_stall,
    input wire logic o_cpu_start,
    input wire logic [31:0] o_cpu_boot_addr,
    input wire logic o_host_access,
    input wire logic o_host_irq_bit,
    input wire logic o_cpu_irq,
    input wire logic o_rom_rd,
    input wire logic o_mem_we,
    input wire logic [31:0] o_mem_addr
);
    // all checks on the core clock, quiet during system reset except the reset state check
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    property p_rst_state;
        disable iff (1'b0) i_rst |=> o_periph_reset && o_cpu_stall
            && !o_host_irq_bit;
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("rst state");
    property p_pin_reset;
        (!i_dev_reset_n) [*4] |-> o_periph_reset && o_cpu_stall;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("pin reset");
    property p_start;
        o_cpu_start |-> (!o_cpu_stall && o_cpu_boot_addr == 32'h0)
            ##1 !o_cpu_start;
    endproperty
    a_start: assert property (p_start)
        else $error("start pulse");
    property p_stall_exit;
        $fell(o_cpu_stall) |-> o_cpu_start;
    endproperty
    a_stall_exit: assert property (p_stall_exit)
        else $error("exit");
    property p_host_release;
        o_host_access && i_host_irq_set |=> o_cpu_start && o_host_irq_bit
            && !o_cpu_irq && !o_host_access;
    endproperty
    a_host_release: assert property (p_host_release)
        else $error("host");
    property p_irq_refused;
        o_host_irq_bit && i_host_irq_set |=> !o_cpu_irq;
    endproperty
    a_irq_refused: assert property (p_irq_refused)
        else $error("refuse");
    property p_irq_accept;
        !o_cpu_stall && !o_host_irq_bit && i_host_irq_set
            |=> o_cpu_irq && o_host_irq_bit;
    endproperty
    a_irq_accept: assert property (p_irq_accept)
        else $error("accept");
    property p_copy_stalled;
        o_rom_rd || o_mem_we |-> o_cpu_stall && !o_periph_reset && !o_host_access;
    endproperty
    a_copy_stalled: assert property (p_copy_stalled)
        else $error("cp");
    property p_word_write;
        o_mem_we |-> o_mem_addr[1:0] == 2'h0 && !o_rom_rd ##1 !o_mem_we;
    endproperty
    a_word_write: assert property (p_word_write)
        else $error("word");
    // main scenarios reached
    c_host: cover property (o_host_access && i_host_irq_set);
    c_copy: cover property (o_mem_we);
    c_irq: cover property (o_cpu_irq);
endmodule // bmc_checker

bind bmc_boot_ctrl bmc_checker chk (.*);

/* File: bmc_rom_model.sv */
// byte rom model answering each read with one valid pulse
// assumes the reader holds rd and addr until valid is seen
`timescale 1ns/100ps
module bmc_rom_model (
    input wire logic i_core_clk,
    input wire logic i_rom_rd,
    input wire logic [31:0] i_rom_addr,
    input wire logic i_slow,
    output logic [7:0] o_rom_data = 8'h00,
    output logic o_rom_valid = 1'b0
);
    logic [3:0] wait_cnt = 4'h0;
    // answer after 0 or 5 wait cycles, idle data toggles
    always_ff @(posedge i_core_clk) begin
        if (i_rom_rd && !o_rom_valid
                && wait_cnt >= (i_slow ? 4'h5 : 4'h0)) begin
            o_rom_valid <= 1'b1;
            o_rom_data <= i_rom_addr[7:0] + 8'h31;
            wait_cnt <= 4'h0;
        end else begin
            o_rom_valid <= 1'b0;
            o_rom_data <= ~o_rom_data;
            wait_cnt <= i_rom_rd ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // bmc_rom_model

/* File: boot_mode_controller_bench.sv */
// bench for the boot controller: boot case rows, then a reset test
// assumes package, interface, copier, checker and rom model compiled
`timescale 1ns/100ps
module boot_mode_controller_bench;
    localparam int NB = 16;
    logic i_core_clk = 1'b0, i_rst = 1'b1, i_dev_reset_n = 1'b0;
    logic [1:0] i_boot_mode = 2'h0;
    logic i_pci_sel = 1'b0, i_big_endian = 1'b0, i_host_irq_set = 1'b0;
    logic i_cpu_irq_clear = 1'b0, i_rom_valid, slow = 1'b0;
    logic [7:0] i_rom_data;
    logic o_periph_reset, o_cpu_stall, o_cpu_start, o_host_access;
    logic o_host_pci_sel, o_host_irq_bit, o_cpu_irq, o_rom_rd, o_mem_we;
    logic [31:0] o_cpu_boot_addr, o_rom_addr, o_mem_addr, o_mem_wdata, w;
    logic [31:0] mem [NB/4];
    // row: mode, pci, big endian, slow rom | expected stall, host access
    logic [6:0] rows [6] = '{7'h00, 7'h33, 7'h4E, 7'h52, 7'h78, 7'h23};
    int n_mismatch = 0, total_checks = 0, n_start = 0, n_irq = 0, n_we = 0;

    bmc_boot_ctrl #(.COPY_BYTES(NB)) uut (.*);
    bmc_rom_model rom (.i_core_clk(i_core_clk), .i_rom_rd(o_rom_rd),
        .i_rom_addr(o_rom_addr), .i_slow(slow), .o_rom_data(i_rom_data),
        .o_rom_valid(i_rom_valid));

    // 50 ns clock
    initial begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    // count pulses and capture words written (index bits fit NB = 16)
    always @(posedge i_core_clk) begin
        n_start = n_start + int'(o_cpu_start);
        n_irq = n_irq + int'(o_cpu_irq);
        if (o_mem_we) begin
            mem[o_mem_addr[3:2]] = o_mem_wdata;
            n_we++;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #5;
    endtask
    task automatic chk1(input string s, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk32(input string s, input logic [31:0] e,
            input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one-cycle pulse of the host set (1) or cpu clear (0)
    task automatic pulse(input logic set);
        {i_host_irq_set, i_cpu_irq_clear} = {set, !set};
        step(1);
        {i_host_irq_set, i_cpu_irq_clear} = 2'h0;
    endtask
    // one boot with the straps and expectations of a row
    task automatic boot(input logic [6:0] r);
        i_dev_reset_n = 1'b0;
        {i_boot_mode, i_pci_sel, i_big_endian, slow} = r[6:2];
        step(5);
        chk1("periph_reset", 1'b1, o_periph_reset);
        n_start = 0;
        n_irq = 0;
        n_we = 0;
        i_dev_reset_n = 1'b1;
        step(3);
        {i_boot_mode, i_pci_sel} = ~r[6:4];
        step(1);
        chk1("periph_reset", 1'b0, o_periph_reset);
        chk1("cpu_stall", r[1], o_cpu_stall);
        chk1("host_access", r[0], o_host_access);
        chk1("pci_sel", r[4], o_host_pci_sel);
        chk32("starts", {31'h0, !r[1]}, 32'(n_start));
        if (r[6:5] == 2'h2) begin
            pulse(1'b1);
            step(2);
            chk32("starts", 32'h0, 32'(n_start));
            for (int k = 0; k < 400 && n_start == 0; k++) step(1);
            if (n_start == 0) begin
                n_mismatch++;
                give_verdict();
            end
            chk1("cpu_stall", 1'b0, o_cpu_stall);
            chk32("words", 32'(NB/4), 32'(n_we));
            chk32("irqs", 32'h0, 32'(n_irq));
            for (int k = 0; k < NB/4; k++) begin
                for (int b = 0; b < 4; b++)
                    w[8*b +: 8] = 8'(4*k + (r[3] ? 3-b : b)) + 8'h31;
                chk32("word", w, mem[k]);
            end
        end
        if (r[6:5] == 2'h1) begin
            pulse(1'b1);
            step(2);
            chk32("starts", 32'h1, 32'(n_start));
            chk1("irq_bit", 1'b1, o_host_irq_bit);
            chk32("irqs", 32'h0, 32'(n_irq));
            pulse(1'b1);
            step(2);
            chk32("irqs", 32'h0, 32'(n_irq));
            pulse(1'b0);
            step(1);
            pulse(1'b1);
            step(2);
            chk32("irqs", 32'h1, 32'(n_irq));
        end
    endtask

    // reset, boot rows, then system reset in mid-run
    initial begin
        step(4);
        i_rst = 1'b0;
        foreach (rows[i]) boot(rows[i]);
        i_rst = 1'b1;
        step(1);
        chk1("periph_reset", 1'b1, o_periph_reset);
        chk1("cpu_stall", 1'b1, o_cpu_stall);
        chk1("irq_bit", 1'b0, o_host_irq_bit);
        // release in mid-run: pin is high, straps now select memory boot
        i_rst = 1'b0;
        step(3);
        chk1("periph_reset", 1'b0, o_periph_reset);
        chk1("cpu_stall", 1'b1, o_cpu_stall);
        chk1("host_access", 1'b0, o_host_access);
        give_verdict();
    end
endmodule // boot_mode_controller_bench
